// ===== hw/efc_top.sv
// What this block does
// - One 64-byte row is smallest erase unit.
// - Program one eight-byte page at a time.
// - Erased cell reads 0, programmed reads 1.
// - Flash, protect byte, control, vectors at fixed addresses.
// - Rows are consecutive 64-byte blocks from A000.
// - Pump clock divides bus clock by 2, 4 or 8.
// - Two-bit erase size field is read/write.
// - High voltage set only when armed by sequence.
// - High-voltage bit drives pump and array voltage.
// - Margin refused or dropped while high voltage on.
// - Margin bit selects verify read mode.
// - Erase and program selects never both set.
// - Program and erase select bits choose operation.
// - Erase size decodes full, half, eight rows, row.
// - Protected target range clears the select bit.
`timescale 1ns/100ps
module efc_top
	import efc_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_array_rdata,
	input wire logic [3:0] i_protect_bits,
	output logic [7:0] o_rdata,
	output logic o_pump_clk,
	output logic o_pump_on,
	output logic o_array_hv,
	output logic o_margin_read,
	output logic o_prog_mode,
	output logic o_erase_mode,
	output logic [1:0] o_erase_size,
	output logic o_latch_we,
	output logic [15:0] o_latch_addr,
	output logic [7:0] o_latch_data,
	output logic [15:0] o_target_lo,
	output logic [15:0] o_target_hi
);
	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	efc_ctrl_t ctrl_q;
	efc_ctrl_t ctrl_d;
	efc_seq_t seq_q;
	efc_seq_t seq_d;
	logic [3:0] prot_q;
	logic [15:0] tgt_addr_q;
	logic [15:0] tgt_addr_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic lwe_q;
	logic [15:0] laddr_q;
	logic [7:0] ldata_q;
	efc_range_t rng;
	logic blocked;
	logic pump_clk;
	efc_ctrl_t wr_ctrl;

	wire logic [15:0] addr16 = i_addr[15:0];
	// Address map decode.
	wire logic hit_ctrl = (addr16 == EFC_CTRL_ADDR);
	wire logic hit_bpr = (addr16 == EFC_BPR_ADDR);
	wire logic hit_user = (addr16 >= EFC_USER_LO) && (addr16 <= EFC_USER_HI);
	wire logic hit_vec = (addr16 >= EFC_VEC_LO) && (addr16 <= EFC_VEC_HI);
	wire logic hit_array = hit_user || hit_vec;
	wire logic wr_ctrl_s = i_wr && hit_ctrl;
	wire logic rd_bpr_s = i_rd && hit_bpr;
	wire logic wr_array_s = i_wr && hit_array;
	wire logic op_sel = ctrl_q.program_select || ctrl_q.erase_select;
	// Array is unreadable while high voltage is on.
	wire logic array_rd_ok = !ctrl_q.high_voltage_enable;
	assign wr_ctrl = efc_ctrl_t'(i_wdata);

	// ------------------------------------------------------------------
	// Control register next state
	// ------------------------------------------------------------------
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl_s) begin
			ctrl_d.pump_div = wr_ctrl.pump_div;
			ctrl_d.erase_size = wr_ctrl.erase_size;
			ctrl_d.program_select = wr_ctrl.program_select;
			ctrl_d.erase_select = wr_ctrl.erase_select;
			// An erase already selected alone wins a simultaneous request, else program wins, so the pair stays exclusive.
			if (wr_ctrl.program_select && wr_ctrl.erase_select) begin
				ctrl_d.erase_select = ctrl_q.erase_select && !ctrl_q.program_select ? 1'b1 : 1'b0;
				ctrl_d.program_select = !ctrl_d.erase_select;
			end
			// High voltage only from the armed state with an operation selected.
			ctrl_d.high_voltage_enable = wr_ctrl.high_voltage_enable &&
				(ctrl_q.high_voltage_enable || (seq_q == EFC_SEQ_ARMED && op_sel));
			if (!(ctrl_d.program_select || ctrl_d.erase_select)) begin
				ctrl_d.high_voltage_enable = 1'b0;
			end
			// Margin can not be set while high voltage is on.
			ctrl_d.margin = wr_ctrl.margin && !ctrl_q.high_voltage_enable;
		end
		// Rising high voltage drops any pending margin request.
		if (ctrl_d.high_voltage_enable) begin
			ctrl_d.margin = 1'b0;
		end
		// Protected target clears the select, which keeps high voltage off.
		if (seq_q == EFC_SEQ_ARMED && blocked && !ctrl_q.high_voltage_enable) begin
			ctrl_d.program_select = 1'b0;
			ctrl_d.erase_select = 1'b0;
			ctrl_d.high_voltage_enable = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Arming sequence: select, read protect byte, write target
	// ------------------------------------------------------------------
	always_comb begin
		seq_d = seq_q;
		tgt_addr_d = tgt_addr_q;
		case (seq_q)
			EFC_SEQ_IDLE: begin
				if (op_sel) begin
					seq_d = EFC_SEQ_SEL;
				end
			end
			EFC_SEQ_SEL: begin
				if (rd_bpr_s) begin
					seq_d = EFC_SEQ_BPR;
				end
			end
			EFC_SEQ_BPR: begin
				if (wr_array_s) begin
					seq_d = EFC_SEQ_ARMED;
					tgt_addr_d = addr16;
				end
			end
			default: begin
				seq_d = EFC_SEQ_ARMED;
			end
		endcase
		// Dropping the select restarts the sequence.
		if (!(ctrl_d.program_select || ctrl_d.erase_select)) begin
			seq_d = EFC_SEQ_IDLE;
		end
	end

	efc_range u_range (
		.i_addr(tgt_addr_q),
		.i_erase(ctrl_q.erase_select),
		.i_size(ctrl_q.erase_size),
		.i_protect(prot_q),
		.o_range(rng),
		.o_blocked(blocked)
	);

	efc_pump_div u_div (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_div_sel(ctrl_q.pump_div),
		.i_run(ctrl_q.high_voltage_enable),
		.o_pump_clk(pump_clk)
	);

	// ------------------------------------------------------------------
	// Read data: control, protect byte, array pass-through
	// ------------------------------------------------------------------
	// Array data passes as read: erased 0, programmed 1.
	assign rdata_d = !i_rd ? rdata_q :
		hit_ctrl ? ctrl_q :
		hit_bpr ? {4'h0, i_protect_bits} :
		(hit_array && array_rd_ok) ? i_array_rdata : EFC_DATA_ERASED;

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_q <= efc_ctrl_t'(EFC_CTRL_RST);
			seq_q <= EFC_SEQ_IDLE;
			prot_q <= 4'h0;
			tgt_addr_q <= EFC_USER_LO;
			rdata_q <= EFC_DATA_ERASED;
		end else begin
			ctrl_q <= ctrl_d;
			seq_q <= seq_d;
			tgt_addr_q <= tgt_addr_d;
			rdata_q <= rdata_d;
			if (rd_bpr_s) begin
				prot_q <= i_protect_bits;
			end
		end
	end

	// Page write latch strobes for programming; erase writes load its address and data without a strobe.
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lwe_q <= 1'b0;
			laddr_q <= 16'h0000;
			ldata_q <= EFC_DATA_ERASED;
		end else begin
			lwe_q <= wr_array_s && ctrl_q.program_select && !ctrl_q.high_voltage_enable
				&& seq_q != EFC_SEQ_SEL;
			laddr_q <= wr_array_s ? addr16 : laddr_q;
			ldata_q <= wr_array_s ? i_wdata : ldata_q;
		end
	end

	// ------------------------------------------------------------------
	// Outputs toward the array and pump
	// ------------------------------------------------------------------
	logic hv_q;
	logic margin_q;
	logic [15:0] tlo_q;
	logic [15:0] thi_q;
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			hv_q <= 1'b0;
			margin_q <= 1'b0;
			tlo_q <= EFC_USER_LO;
			thi_q <= EFC_USER_LO;
		end else begin
			hv_q <= ctrl_q.high_voltage_enable;
			margin_q <= ctrl_q.margin;
			tlo_q <= rng.lo;
			thi_q <= rng.hi;
		end
	end

	assign o_rdata = rdata_q;
	assign o_pump_clk = pump_clk;
	assign o_pump_on = hv_q;
	assign o_array_hv = hv_q;
	assign o_margin_read = margin_q;
	assign o_prog_mode = ctrl_q.program_select;
	assign o_erase_mode = ctrl_q.erase_select;
	assign o_erase_size = ctrl_q.erase_size;
	assign o_latch_we = lwe_q;
	assign o_latch_addr = laddr_q;
	assign o_latch_data = ldata_q;
	assign o_target_lo = tlo_q;
	assign o_target_hi = thi_q;
endmodule

// ===== hw/efc_pkg.sv
package efc_pkg;

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam logic [15:0] EFC_USER_LO = 16'hA000;
	localparam logic [15:0] EFC_USER_HI = 16'hFDFF;
	localparam logic [15:0] EFC_CTRL_ADDR = 16'hFE08;
	localparam logic [15:0] EFC_BPR_ADDR = 16'hFF80;
	localparam logic [15:0] EFC_VEC_LO = 16'hFFD2;
	localparam logic [15:0] EFC_VEC_HI = 16'hFFFF;
	localparam logic [15:0] EFC_ARRAY_TOP = 16'hFFFF;

	// ------------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------------
	localparam int EFC_ROW_BYTES = 64;
	localparam int EFC_PAGE_BYTES = 8;
	localparam int EFC_ROW_SHIFT = 6;
	localparam int EFC_PAGE_SHIFT = 3;
	localparam int EFC_BLK8_SHIFT = 9;
	localparam logic [15:0] EFC_HALF_BASE = 16'hC000;

	// ------------------------------------------------------------------
	// Control register fields and reset value
	// ------------------------------------------------------------------
	localparam int EFC_B_DIV_HI = 7;
	localparam int EFC_B_DIV_LO = 6;
	localparam int EFC_B_BLK_HI = 5;
	localparam int EFC_B_BLK_LO = 4;
	localparam int EFC_B_HIGH_VOLTAGE_ENABLE = 3;
	localparam int EFC_B_MARGIN = 2;
	localparam int EFC_B_ERASE = 1;
	localparam int EFC_B_PGM = 0;
	localparam logic [7:0] EFC_CTRL_RST = 8'h00;
	localparam logic [7:0] EFC_DATA_ERASED = 8'h00;
	localparam logic [1:0] EFC_CNT_RST = 2'h0;

	// ------------------------------------------------------------------
	// Block protect base addresses, one per protect bit
	// ------------------------------------------------------------------
	localparam logic [15:0] EFC_BP3_BASE = 16'hF000;
	localparam logic [15:0] EFC_BP2_BASE = 16'hE000;
	localparam logic [15:0] EFC_BP1_BASE = 16'hC000;
	localparam logic [15:0] EFC_BP0_BASE = 16'hA000;

	typedef enum logic [1:0] {
		EFC_ERS_FULL = 2'b00,
		EFC_ERS_HALF = 2'b01,
		EFC_ERS_EIGHT = 2'b10,
		EFC_ERS_ROW = 2'b11
	} efc_ers_t;

	typedef enum logic [1:0] {
		EFC_SEQ_IDLE = 2'b00,
		EFC_SEQ_SEL = 2'b01,
		EFC_SEQ_BPR = 2'b10,
		EFC_SEQ_ARMED = 2'b11
	} efc_seq_t;

	typedef struct packed {
		logic [1:0] pump_div;
		logic [1:0] erase_size;
		logic high_voltage_enable;
		logic margin;
		logic erase_select;
		logic program_select;
	} efc_ctrl_t;

	typedef struct packed {
		logic [15:0] lo;
		logic [15:0] hi;
	} efc_range_t;

endpackage

// ===== hw/efc_pump_div.sv
`timescale 1ns/100ps
module efc_pump_div
	import efc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [1:0] i_div_sel,
	input wire logic i_run,
	output logic o_pump_clk
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic clk_q;
	logic clk_d;
	wire logic div1 = (i_div_sel == 2'h0);
	wire logic div4 = (i_div_sel == 2'h3);

	// Code 00 toggles on every edge, the fastest a register can go.
	// The other codes stretch that rate by two or four so the ratios hold.
	wire logic flip = div1 || (div4 ? (cnt_q == 2'h3) : cnt_q[0]);
	assign cnt_d = i_run ? (cnt_q + 2'h1) : EFC_CNT_RST;
	assign clk_d = !i_run ? 1'b0 : flip ? !clk_q : clk_q;

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_q <= EFC_CNT_RST;
			clk_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
		end
	end

	assign o_pump_clk = clk_q;
endmodule

// ===== hw/efc_range.sv
`timescale 1ns/100ps
module efc_range
	import efc_pkg::*;
(
	input wire logic [15:0] i_addr,
	input wire logic i_erase,
	input wire logic [1:0] i_size,
	input wire logic [3:0] i_protect,
	output efc_range_t o_range,
	output logic o_blocked
);
	logic [15:0] prot_lo;

	// Erase size decode: full, half, eight rows, one row.
	always_comb begin
		o_range.lo = {i_addr[15:EFC_PAGE_SHIFT], 3'h0};
		o_range.hi = {i_addr[15:EFC_PAGE_SHIFT], 3'h7};
		if (i_erase) begin
			case (efc_ers_t'(i_size))
				EFC_ERS_FULL: begin
					o_range.lo = EFC_USER_LO;
					o_range.hi = EFC_ARRAY_TOP;
				end
				EFC_ERS_HALF: begin
					o_range.lo = (i_addr >= EFC_HALF_BASE) ? EFC_HALF_BASE : EFC_USER_LO;
					o_range.hi = (i_addr >= EFC_HALF_BASE) ? EFC_ARRAY_TOP : EFC_HALF_BASE - 16'h1;
				end
				EFC_ERS_EIGHT: begin
					o_range.lo = {i_addr[15:EFC_BLK8_SHIFT], 9'h000};
					o_range.hi = {i_addr[15:EFC_BLK8_SHIFT], 9'h1FF};
				end
				default: begin
					o_range.lo = {i_addr[15:EFC_ROW_SHIFT], 6'h00};
					o_range.hi = {i_addr[15:EFC_ROW_SHIFT], 6'h3F};
				end
			endcase
		end
	end

	// Lowest protected base wins; all protected ranges run to the top.
	assign prot_lo = i_protect[0] ? EFC_BP0_BASE : i_protect[1] ? EFC_BP1_BASE :
		i_protect[2] ? EFC_BP2_BASE : EFC_BP3_BASE;
	assign o_blocked = (|i_protect) && (o_range.hi >= prot_lo);
endmodule

// ===== sim/efc_top_sva.sv
`timescale 1ns/100ps
module efc_top_sva
	import efc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [15:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] i_array_rdata,
	input wire logic [3:0] i_protect_bits,
	input wire logic [7:0] o_rdata,
	input wire logic o_pump_clk,
	input wire logic o_pump_on,
	input wire logic o_array_hv,
	input wire logic o_margin_read,
	input wire logic o_prog_mode,
	input wire logic o_erase_mode,
	input wire logic [1:0] o_erase_size
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	wire logic in_user = i_addr >= EFC_USER_LO && i_addr <= EFC_USER_HI;
	wire logic no_mode = !o_pump_on && !o_prog_mode && !o_erase_mode;
	chk_sel_excl: assert property (!(o_prog_mode && o_erase_mode))
		else $error("program and erase both selected");
	chk_hv_copy: assert property (o_pump_on == o_array_hv)
		else $error("pump and array voltage differ");
	chk_hv_needs_sel: assert property ($rose(o_pump_on) |-> $past(o_prog_mode) || $past(o_erase_mode))
		else $error("high voltage without a selected operation");
	chk_margin_hv: assert property (!(o_pump_on && o_margin_read))
		else $error("margin read during high voltage");
	chk_pump_idle: assert property (!o_pump_on && !$past(o_pump_on) |-> !o_pump_clk)
		else $error("pump clock runs with pump off");
	chk_array_read: assert property (i_rd && in_user && no_mode |=> o_rdata == $past(i_array_rdata))
		else $error("array read data differs");
	chk_ctrl_read: assert property (i_rd && i_addr == EFC_CTRL_ADDR |=>
		o_rdata[5:4] == $past(o_erase_size) && o_rdata[1] == $past(o_erase_mode) &&
		o_rdata[0] == $past(o_prog_mode))
		else $error("control read differs from mode outputs");
	chk_bpr_read: assert property (i_rd && i_addr == EFC_BPR_ADDR |=>
		o_rdata == {4'h0, $past(i_protect_bits)})
		else $error("protect byte read differs");
	cover property ($rose(o_pump_on));
	cover property ($rose(o_margin_read));
	cover property ($rose(o_erase_mode));
endmodule
bind efc_top efc_top_sva i_efc_top_sva (.i_clk, .i_sys_rst, .i_addr, .i_rd, .i_array_rdata,
	.i_protect_bits, .o_rdata, .o_pump_clk, .o_pump_on, .o_array_hv, .o_margin_read,
	.o_prog_mode, .o_erase_mode, .o_erase_size);

// ===== sim/efc_flash_model.sv
`timescale 1ns/100ps
module efc_flash_model
	import efc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [15:0] i_addr,
	input wire logic i_hv,
	input wire logic i_prog,
	input wire logic [15:0] i_latch_addr,
	input wire logic [7:0] i_latch_data,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:65535];
	logic hv_q = 1'b0;
	initial begin
		foreach (mem[k]) mem[k] = EFC_DATA_ERASED;
	end
	assign o_rdata = mem[i_addr];
	// Programming only sets bits, so a cell is never cleared without an erase.
	always @(posedge i_clk) begin
		hv_q <= i_hv;
		if (i_hv && !hv_q && i_prog) begin
			mem[i_latch_addr] <= mem[i_latch_addr] | i_latch_data;
		end
	end
endmodule

// ===== sim/tb_efc_top.sv
`timescale 1ns/100ps
module tb_efc_top
	import efc_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [3:0] i_protect_bits = 4'h0;
	logic [7:0] i_array_rdata, o_rdata, o_latch_data, d;
	logic o_pump_clk, o_pump_on, o_array_hv, o_margin_read, o_prog_mode, o_erase_mode, o_latch_we, p;
	logic [1:0] o_erase_size;
	logic [15:0] o_latch_addr, o_target_lo, o_target_hi, a, m, elo, ehi;
	logic [31:0] rng = 32'h33;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	int ctrl_m = 0;
	int seq = 0;
	int n_lwe = 0;
	int n, ex, lw;
	always #2 i_clk = ~i_clk;
	efc_top i_efc_top (.*);
	efc_flash_model i_efc_flash_model (.i_clk(i_clk), .i_addr(i_addr), .i_hv(o_array_hv),
		.i_prog(o_prog_mode), .i_latch_addr(o_latch_addr), .i_latch_data(o_latch_data),
		.o_rdata(i_array_rdata));
	// ----
	// Tasks
	// ----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
		i_addr <= ad;
		i_wdata <= dt;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] exp);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		check("read data", o_rdata, exp);
		@(posedge i_clk);
	endtask
	// Bench model of the control byte; the sequence state must be armed before high voltage.
	task automatic ctl_wr(input logic [7:0] dt);
		n = dt;
		if ((n & 3) == 3) n = ((ctrl_m & 3) == 2) ? n & ~1 : n & ~2;
		if (!(seq == 3 && (n & 3))) n = n & ~8;
		if ((n & 8) || (ctrl_m & 8)) n = n & ~4;
		if ((n & 3) == 0) seq = 0;
		else if (seq == 0) seq = 1;
		ctrl_m = n;
		wr(EFC_CTRL_ADDR, dt);
	endtask
	task automatic arm(input logic [15:0] ad, input logic [7:0] dt);
		lw = n_lwe + (ctrl_m & 1);
		rd(EFC_BPR_ADDR, {4'h0, i_protect_bits});
		if (seq == 1) seq = 2;
		wr(ad, dt);
		if (seq == 2) seq = 3;
		if (i_protect_bits != 4'h0) begin
			ctrl_m = ctrl_m & ~3;
			seq = 0;
		end
		repeat (2) @(negedge i_clk);
		check("target base", o_target_lo, elo);
		check("target top", o_target_hi, ehi);
		check("latch strobe", 16'(n_lwe), 16'(lw));
		check("latch addr", o_latch_addr, ad);
		check("latch data", o_latch_data, dt);
		@(posedge i_clk);
	endtask
	task automatic results();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	always @(posedge i_clk) begin
		cycles++;
		if (o_latch_we) begin
			n_lwe++;
		end
		if (cycles == 4000) begin
			failures++;
			results();
		end
	end
	// ----
	// Scenarios
	// ----
	initial begin
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(EFC_CTRL_ADDR, 8'h00);
		for (int s = 0; s < 4; s++) begin
			ctl_wr(8'(s << 4));
			rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		end
		ctl_wr(8'h03);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		ctl_wr(8'h02);
		ctl_wr(8'h03);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		ctl_wr(8'h09);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		for (int s = 0; s < 4; s++) begin
			rng = xs(rng);
			a = 16'hA000 + 16'(rng % 32'h5E00);
			m = (s == 3) ? 16'hFFC0 : 16'hFE00;
			p = (a >= 16'hC000);
			elo = (s == 0) ? 16'hA000 : (s == 1) ? (p ? 16'hC000 : 16'hA000) : a & m;
			ehi = (s == 0) ? 16'hFFFF : (s == 1) ? (p ? 16'hFFFF : 16'hBFFF) : a | ~m;
			ctl_wr(8'((s << 4) | 2));
			arm(a, 8'hFF);
			ctl_wr(8'h00);
		end
		// Each row gets a single page program, well inside its budget.
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			a = 16'hA000 + 16'(k * 64) + 16'(rng[5:0]);
			d = rng[31:24];
			elo = a & 16'hFFF8;
			ehi = a | 16'h0007;
			ctl_wr({2'(k), 6'h01});
			arm(a, d);
			ctl_wr({2'(k), 6'h09});
			rd(EFC_CTRL_ADDR, 8'(ctrl_m));
			check("pump on", o_pump_on, 16'h1);
			ex = 32 >> ((k == 0) ? 0 : (k == 3) ? 2 : 1);
			n = 0;
			p = o_pump_clk;
			repeat (64) begin
				@(negedge i_clk);
				n += int'(o_pump_clk && !p);
				p = o_pump_clk;
			end
			@(posedge i_clk);
			check("pump edges", 16'(n >= ex - 1 && n <= ex + 1), 16'h1);
			ctl_wr({2'(k), 6'h0D});
			rd(EFC_CTRL_ADDR, 8'(ctrl_m));
			ctl_wr({2'(k), 6'h01});
			ctl_wr({2'(k), 6'h05});
			rd(EFC_CTRL_ADDR, 8'(ctrl_m));
			check("margin out", o_margin_read, 16'h1);
			ctl_wr(8'h00);
			rd(a, d);
		end
		i_protect_bits <= 4'h1;
		ctl_wr(8'h01);
		elo = 16'hB000;
		ehi = 16'hB007;
		arm(16'hB000, 8'h55);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		ctl_wr(8'h09);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		ctl_wr(8'hF5);
		rd(EFC_CTRL_ADDR, 8'(ctrl_m));
		i_sys_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		ctrl_m = 0;
		seq = 0;
		rd(EFC_CTRL_ADDR, 8'h00);
		check("margin out", o_margin_read, 16'h0);
		rd(a, d);
		results();
	end
endmodule
